/* hdl/trig_cmd_defs.svh */
`ifndef TRIG_CMD_DEFS_SVH
`define TRIG_CMD_DEFS_SVH

// Input buffer depth in characters, terminator included
`define IBUF_DEPTH 100
`define IBUF_PTR_W 7
// Status bit positions
`define OPC_READING_AVAIL_BIT 8
`define SER_EXEC_ERR_BIT 4
`define SER_CMD_ERR_BIT 5
// Cycle count limits; zero encodes continuous
`define CYCLE_COUNT_MAX 14'h270F
`define CYCLE_COUNT_CONTINUOUS_COUNT_TOKEN 14'h0000
// Delay limit in seconds (99:59:59)
`define DELAY_MAX_SEC 19'h57E3F
`define DELAY_RST 19'h00000
// Number of scan lists
`define NUM_LISTS 4
// Resolution codes: 0 -> 1, 1 -> 0.1, 2 -> 0.01, 3 -> 0.001
`define RES_RST 2'h1

`endif

/* hdl/trig_cmd_pkg.sv */
`default_nettype none
package trig_cmd_pkg;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_CONF_QUERY,
    OP_MEASURE,
    OP_CONFIGURE,
    OP_SET_UNIT,
    OP_GET_UNIT,
    OP_SET_RES,
    OP_GET_RES,
    OP_BEGIN_SINGLE_READING,
    OP_COMMON_TRIGGER,
    OP_FETCH,
    OP_READ,
    OP_ABORT,
    OP_SET_TRIG_MODE,
    OP_GET_TRIG_MODE,
    OP_SET_COUNT,
    OP_GET_COUNT,
    OP_SET_DELAY,
    OP_GET_DELAY,
    OP_GET_SAMPLE_COUNT,
    OP_SET_SAMPLE_DELAY,
    OP_GET_SAMPLE_DELAY
  } opcode_t;

  typedef enum logic [1:0] {
    UNIT_C,
    UNIT_F,
    UNIT_K
  } temp_unit_t;

  typedef enum logic [2:0] {
    FN_DEFAULT,
    FN_TEMPERATURE,
    FN_RESISTANCE,
    FN_VOLTAGE
  } fetch_fn_t;

  typedef enum logic [1:0] {
    RUN_HOLD,
    RUN_RUN,
    RUN_SINGLE
  } run_state_t;

  typedef enum logic [1:0] {
    EXEC_IDLE,
    EXEC_DECODE,
    EXEC_MEASURE,
    EXEC_RESPOND
  } exec_state_t;

  // Decoded command from the character parser; one-cycle valid
  typedef struct packed {
    logic valid;
    opcode_t op;
    logic list_sel;      // Command names a scan list
    logic [1:0] list_idx;
    fetch_fn_t fn;
    logic stat_mean;     // Rolling mean variant
    logic stat_dev;      // Rolling deviation variant
    logic continuous;    // Continuous trigger or continuous count
    logic [13:0] count;
    logic [18:0] delay_sec;
    temp_unit_t unit;
    logic [1:0] res;
    logic cfg_rtd;       // Configure/measure selects resistance probe
    logic cfg_diff;      // Two-channel difference channel chosen
  } cmd_t;

  // Measurement engine handshake result
  typedef struct packed {
    logic done;
    logic is_rtd;
    logic pt25;
    logic [31:0] temp;
    logic [31:0] resist;
    logic [31:0] volt;    // Terminal plus junction equivalent, millivolts
    logic [31:0] temp_mean;
    logic [31:0] temp_dev;
    logic [31:0] res_mean;
    logic [31:0] res_dev;
    logic [31:0] volt_mean;
    logic [31:0] volt_dev;
  } meas_t;

  // Response to the output formatter
  typedef struct packed {
    logic valid;
    opcode_t op;
    logic error_value;
    fetch_fn_t fn;
    logic stat_mean;
    logic stat_dev;
    logic [2:0] digits;   // Decimal places to print
    temp_unit_t unit;
    logic [31:0] value;
    logic continuous_count_token_token;     // Print the continuous count token
  } resp_t;

endpackage
`default_nettype wire

/* hdl/trig_cmd_engine.sv */
`timescale 1ns/100ps
`default_nettype none
`include "trig_cmd_defs.svh"

// Notes on behaviour
// R01: Configuration query reports channel and probe set, measurement untouched.
// R02: Measure query aborts cycle, configures, sets single, outputs one reading.
// R03: Unit C, F or K applies to responses and is reported.
// R04: Resolution of 1 to 0.001 degrees applies to responses and is reported.
// R05: Begin_single_reading ends cycle, sets single, stores one reading, sets available bit 8.
// R06: Fetch outputs stored reading and clears the available flag.
// R07: Common trigger acts as begin_single_reading, accepted on the parallel bus only.
// R08: Default fetch function is temperature, then last used; measure/read reset it.
// R09: Fetched voltage is terminal plus junction equivalent in milli format.
// R10: Function mismatching last measurement returns error value and execution error.
// R11: Difference channel allows temperature fetch only.
// R12: Serial continuous read then function fetch streams that function each reading.
// R13: Rolling statistics add mean and deviation; finer resolutions as specified.
// R14: Read measures and outputs; once in single, continuously in continuous mode.
// R15: Serial abort stops, clears buffers, run becomes hold, single stays single.
// R16: Trigger mode write ends cycle; continuous cancelled by single, abort, configure.
// R17: Parallel bus forces single; continuous request ignored with command error.
// R18: General and four list cycle counts 1..9999 or continuous; change ends cycle. The code ends the cycle on a list count change only when that list is in use.
// R19: General and list cycle delays up to 99:59:59; write ends cycle, sets hold.
// R20: Sample count equals cycle count, times active channels for a list.
// R21: List sample delay up to 99:59:59, default zero; change in use sets hold.
// R22: Characters buffer up to 100; execution waits for the terminator.
// R23: Execution error sets standard event bit 4.
// R24: Command error sets standard event bit 5.
// R25: Static link select gates serial-only and bus-only commands.
module trig_cmd_engine
  import trig_cmd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic link_is_bus_i,
  input wire logic char_valid_i,
  input wire logic char_term_i,
  output logic char_ready_o,
  input wire trig_cmd_pkg::cmd_t cmd_i,
  output logic cmd_ready_o,
  input wire trig_cmd_pkg::meas_t meas_i,
  input wire logic stats_enabled_i,
  input wire logic [1:0] active_list_i,
  input wire logic scan_enabled_i,
  input wire logic [3:0] list_channels_i [`NUM_LISTS],
  output logic meas_start_o,
  output logic cycle_stop_o,
  output logic ibuf_clear_o,
  output logic obuf_clear_o,
  output trig_cmd_pkg::resp_t resp_o,
  input wire logic resp_ready_i,
  output logic [15:0] oper_cond_o,
  output logic [7:0] std_event_o,
  output run_state_t run_state_o,
  output logic trig_continuous_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    exec_state_t st;
    logic [`IBUF_PTR_W-1:0] fill;
    logic [`IBUF_PTR_W-1:0] msgs;
    opcode_t pend_op;
    logic to_output;
    logic avail;
    fetch_fn_t last_fn;
    logic stream;
    fetch_fn_t stream_fn;
    logic streaming_read;
    temp_unit_t unit;
    logic [1:0] res;
    logic continuous_count_token_mode;
    run_state_t run;
    logic diff;
    logic rtd;
    logic [13:0] gen_count;
    logic [`NUM_LISTS-1:0][13:0] list_count;
    logic [18:0] gen_delay;
    logic [`NUM_LISTS-1:0][18:0] list_delay;
    logic [`NUM_LISTS-1:0][18:0] samp_delay;
    logic exec_err;
    logic cmd_err;
    meas_t last;
    resp_t resp;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic in_use;
  logic [31:0] pick;
  logic bad_fn;
  fetch_fn_t fn_eff;
  logic [17:0] samp_prod;

  // Scan list in use is the one the scanner is running
  assign in_use = scan_enabled_i && (cmd_i.list_idx == active_list_i);
  // Input characters are refused once the buffer holds its limit
  assign char_ready_o = (s_q.fill < 7'(`IBUF_DEPTH)); // R22
  assign cmd_ready_o = (s_q.st == EXEC_IDLE) && (s_q.msgs != '0); // R22

  // ****************************************
  // Fetch function resolution
  // ****************************************
  always_comb
  begin
    fn_eff = (cmd_i.fn == FN_DEFAULT) ? s_q.last_fn : cmd_i.fn; // R08
    bad_fn = 1'b0;
    if (s_q.diff && fn_eff != FN_TEMPERATURE)
      bad_fn = 1'b1; // R11
    if (fn_eff == FN_VOLTAGE && s_q.rtd)
      bad_fn = 1'b1; // R10
    if (fn_eff == FN_RESISTANCE && !s_q.rtd)
      bad_fn = 1'b1; // R10
    if ((cmd_i.stat_mean || cmd_i.stat_dev) && !stats_enabled_i)
      bad_fn = 1'b1; // R13
    case (fn_eff)
      FN_RESISTANCE:
        pick = cmd_i.stat_mean ? s_q.last.res_mean :
               cmd_i.stat_dev ? s_q.last.res_dev : s_q.last.resist; // R13
      FN_VOLTAGE:
        pick = cmd_i.stat_mean ? s_q.last.volt_mean :
               cmd_i.stat_dev ? s_q.last.volt_dev : s_q.last.volt; // R09
      default:
        pick = cmd_i.stat_mean ? s_q.last.temp_mean :
               cmd_i.stat_dev ? s_q.last.temp_dev : s_q.last.temp;
    endcase
    // Widen before multiplying so 9999 times 15 channels keeps its top bits
    samp_prod = 18'(s_q.list_count[cmd_i.list_idx]) * 18'(list_channels_i[cmd_i.list_idx]); // R20
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    meas_start_o = 1'b0;
    cycle_stop_o = 1'b0;
    ibuf_clear_o = 1'b0;
    obuf_clear_o = 1'b0;
    s_d.exec_err = 1'b0;
    s_d.cmd_err = 1'b0;
    if (s_q.resp.valid && resp_ready_i)
      s_d.resp.valid = 1'b0;
    // Buffer accounting: a message counts only once terminated
    if (char_valid_i && char_ready_o)
      s_d.fill = s_q.fill + 7'h01; // R22
    if (char_valid_i && char_ready_o && char_term_i)
      s_d.msgs = s_d.msgs + 7'h01; // R22
    if (cmd_i.valid && cmd_ready_o)
      s_d.msgs = s_d.msgs - 7'h01;
    if (s_d.msgs == '0 && !(char_valid_i && !char_term_i))
      s_d.fill = s_q.fill & {`IBUF_PTR_W{char_valid_i}};
    case (s_q.st)
      EXEC_IDLE:
      begin
        if (cmd_i.valid && cmd_ready_o)
        begin
          s_d.resp.op = cmd_i.op;
          s_d.resp.unit = s_q.unit; // R03
          s_d.resp.digits = {1'b0, s_q.res}; // R04
          s_d.resp.continuous_count_token_token = 1'b0;
          s_d.resp.error_value = 1'b0;
          s_d.resp.fn = FN_TEMPERATURE;
          s_d.resp.stat_mean = 1'b0;
          s_d.resp.stat_dev = 1'b0;
          case (cmd_i.op)
            OP_CONF_QUERY:
              s_d.resp.valid = 1'b1; // R01
            OP_MEASURE, OP_CONFIGURE:
            begin
              cycle_stop_o = 1'b1;
              s_d.rtd = cmd_i.cfg_rtd;
              s_d.diff = cmd_i.cfg_diff;
              s_d.continuous_count_token_mode = 1'b0; // R16
              s_d.stream = 1'b0;
              if (cmd_i.op == OP_MEASURE)
              begin
                s_d.run = RUN_SINGLE; // R02
                s_d.last_fn = FN_TEMPERATURE; // R08
                s_d.to_output = 1'b1;
                s_d.st = EXEC_MEASURE;
                meas_start_o = 1'b1;
              end
              else if (s_q.run == RUN_RUN)
                s_d.run = RUN_HOLD;
            end
            OP_SET_UNIT:
              s_d.unit = cmd_i.unit; // R03
            OP_SET_RES:
              s_d.res = cmd_i.res; // R04
            OP_GET_UNIT, OP_GET_RES, OP_GET_TRIG_MODE:
            begin
              s_d.resp.value = {31'h0, s_q.continuous_count_token_mode}; // R16
              s_d.resp.valid = 1'b1;
            end
            OP_BEGIN_SINGLE_READING, OP_COMMON_TRIGGER:
            begin
              if (cmd_i.op == OP_COMMON_TRIGGER && !link_is_bus_i)
                s_d.cmd_err = 1'b1; // R07 R25
              else
              begin
                cycle_stop_o = 1'b1; // R05
                s_d.run = RUN_SINGLE;
                s_d.continuous_count_token_mode = 1'b0;
                s_d.to_output = 1'b0;
                s_d.st = EXEC_MEASURE;
                meas_start_o = 1'b1;
              end
            end
            OP_FETCH:
            begin
              s_d.avail = 1'b0; // R06
              s_d.last_fn = fn_eff; // R08
              s_d.resp.fn = fn_eff;
              s_d.resp.stat_mean = cmd_i.stat_mean;
              s_d.resp.stat_dev = cmd_i.stat_dev;
              s_d.resp.value = pick;
              s_d.resp.error_value = bad_fn; // R10
              s_d.exec_err = bad_fn; // R23
              s_d.resp.digits = (fn_eff == FN_VOLTAGE) ? 3'h2 : // R09
                  (fn_eff == FN_RESISTANCE && cmd_i.stat_mean) ?
                  ((s_q.last.pt25 && s_q.res == 2'h3) ? 3'h4 : 3'h3) : // R13
                  {1'b0, s_q.res};
              if (cmd_i.stat_dev)
                s_d.resp.digits = s_d.resp.digits + 3'h1; // R13
              s_d.resp.valid = 1'b1;
              if (s_q.streaming_read && !link_is_bus_i && cmd_i.fn != FN_DEFAULT)
              begin
                s_d.stream = 1'b1; // R12
                s_d.stream_fn = fn_eff;
              end
            end
            OP_READ:
            begin
              s_d.last_fn = FN_TEMPERATURE; // R08
              s_d.to_output = 1'b1; // R14
              s_d.stream = 1'b0;
              s_d.streaming_read = s_q.continuous_count_token_mode;
              if (s_q.continuous_count_token_mode)
                s_d.run = RUN_RUN;
              s_d.st = EXEC_MEASURE;
              meas_start_o = 1'b1;
            end
            OP_ABORT:
            begin
              if (link_is_bus_i)
                s_d.cmd_err = 1'b1; // R15 R25
              else
              begin
                cycle_stop_o = 1'b1; // R15
                ibuf_clear_o = 1'b1;
                obuf_clear_o = 1'b1;
                s_d.resp.valid = 1'b0;
                s_d.continuous_count_token_mode = 1'b0; // R16
                s_d.stream = 1'b0;
                s_d.streaming_read = 1'b0;
                if (s_q.run == RUN_RUN)
                  s_d.run = RUN_HOLD;
              end
            end
            OP_SET_TRIG_MODE:
            begin
              if (cmd_i.continuous && link_is_bus_i)
                s_d.cmd_err = 1'b1; // R17
              else
              begin
                cycle_stop_o = 1'b1; // R16
                s_d.continuous_count_token_mode = cmd_i.continuous;
                s_d.stream = s_q.stream && cmd_i.continuous;
              end
            end
            OP_SET_COUNT, OP_SET_DELAY, OP_SET_SAMPLE_DELAY:
            begin
              if (cmd_i.op == OP_SET_COUNT && !cmd_i.list_sel)
                s_d.gen_count = cmd_i.continuous ? `CYCLE_COUNT_CONTINUOUS_COUNT_TOKEN : cmd_i.count; // R18
              else if (cmd_i.op == OP_SET_COUNT)
                s_d.list_count[cmd_i.list_idx] =
                    cmd_i.continuous ? `CYCLE_COUNT_CONTINUOUS_COUNT_TOKEN : cmd_i.count; // R18
              else if (cmd_i.op == OP_SET_DELAY && !cmd_i.list_sel)
                s_d.gen_delay = cmd_i.delay_sec; // R19
              else if (cmd_i.op == OP_SET_DELAY)
                s_d.list_delay[cmd_i.list_idx] = cmd_i.delay_sec; // R19
              else
                s_d.samp_delay[cmd_i.list_idx] = cmd_i.delay_sec; // R21
              if (cmd_i.op == OP_SET_DELAY || !cmd_i.list_sel || in_use)
              begin
                cycle_stop_o = 1'b1; // R18 R19 R21
                s_d.run = RUN_HOLD;
              end
            end
            OP_GET_COUNT, OP_GET_SAMPLE_COUNT:
            begin
              s_d.resp.value = {18'h0, cmd_i.list_sel ?
                  s_q.list_count[cmd_i.list_idx] : s_q.gen_count};
              if (cmd_i.op == OP_GET_SAMPLE_COUNT && cmd_i.list_sel)
                s_d.resp.value = {14'h0, samp_prod}; // R20
              s_d.resp.continuous_count_token_token = (s_d.resp.value == '0); // R18 R20
              s_d.resp.valid = 1'b1;
            end
            OP_GET_DELAY, OP_GET_SAMPLE_DELAY:
            begin
              s_d.resp.value = {13'h0, (cmd_i.op == OP_GET_SAMPLE_DELAY) ?
                  s_q.samp_delay[cmd_i.list_idx] : cmd_i.list_sel ?
                  s_q.list_delay[cmd_i.list_idx] : s_q.gen_delay};
              s_d.resp.valid = 1'b1;
            end
            default:
              s_d.cmd_err = 1'b1; // R24
          endcase
          if (cmd_i.op == OP_GET_UNIT)
            s_d.resp.value = {30'h0, s_q.unit};
          if (cmd_i.op == OP_GET_RES)
            s_d.resp.value = {30'h0, s_q.res};
        end
        else if (meas_i.done && (s_q.streaming_read || s_q.run == RUN_RUN))
        begin
          // Continuous read: a reading completed in a cycle with no command taken goes out
          s_d.last = meas_i;
          s_d.resp.op = OP_READ;
          s_d.resp.fn = s_q.stream ? s_q.stream_fn : FN_TEMPERATURE; // R12
          s_d.resp.value = (s_q.stream && s_q.stream_fn == FN_VOLTAGE) ? meas_i.volt :
              (s_q.stream && s_q.stream_fn == FN_RESISTANCE) ? meas_i.resist : meas_i.temp;
          s_d.resp.valid = 1'b1; // R14
        end
      end
      EXEC_MEASURE:
        if (meas_i.done)
        begin
          s_d.last = meas_i;
          if (s_q.to_output)
          begin
            s_d.resp.value = meas_i.temp; // R02 R14
            s_d.resp.valid = 1'b1;
          end
          else
            s_d.avail = 1'b1; // R05
          s_d.st = EXEC_IDLE;
        end
      default:
        s_d.st = EXEC_IDLE;
    endcase
    if (link_is_bus_i)
      s_d.continuous_count_token_mode = 1'b0; // R17
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '0;
      s_q.res <= `RES_RST;
      s_q.last_fn <= FN_TEMPERATURE;
      s_q.run <= RUN_SINGLE;
    end
    else
      s_q <= s_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb
  begin
    oper_cond_o = '0;
    oper_cond_o[`OPC_READING_AVAIL_BIT] = s_q.avail; // R05
    std_event_o = '0;
    std_event_o[`SER_EXEC_ERR_BIT] = s_q.exec_err; // R23
    std_event_o[`SER_CMD_ERR_BIT] = s_q.cmd_err; // R24
  end

  assign resp_o = s_q.resp;
  assign run_state_o = s_q.run;
  assign trig_continuous_o = s_q.continuous_count_token_mode;

endmodule
`default_nettype wire

/* testbench/trig_cmd_engine_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module trig_cmd_engine_checker
  import trig_cmd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic link_is_bus_i,
  input wire trig_cmd_pkg::cmd_t cmd_i,
  input wire logic cmd_ready_o,
  input wire trig_cmd_pkg::meas_t meas_i,
  input wire logic meas_start_o,
  input wire logic cycle_stop_o,
  input wire logic ibuf_clear_o,
  input wire logic obuf_clear_o,
  input wire trig_cmd_pkg::resp_t resp_o,
  input wire logic resp_ready_i,
  input wire logic [15:0] oper_cond_o,
  input wire logic [7:0] std_event_o,
  input wire run_state_t run_state_o,
  input wire logic trig_continuous_o
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_take(opcode_t o);
    cmd_i.valid && cmd_ready_o && cmd_i.op == o;
  endsequence

  property p_query_answer;
    s_take(OP_GET_UNIT) |=> resp_o.valid && resp_o.op == OP_GET_UNIT;
  endproperty
  property p_init_start;
    s_take(OP_BEGIN_SINGLE_READING) |-> meas_start_o && cycle_stop_o ##1 run_state_o == RUN_SINGLE;
  endproperty
  property p_avail_cause;
    $rose(oper_cond_o[8]) |-> $past(meas_i.done);
  endproperty
  property p_fetch_clear;
    s_take(OP_FETCH) ##0 oper_cond_o[8] |-> ##[1:2] !oper_cond_o[8];
  endproperty
  property p_trg_serial;
    s_take(OP_COMMON_TRIGGER) ##0 !link_is_bus_i |-> !meas_start_o ##[1:2] std_event_o[5];
  endproperty
  property p_bus_single;
    link_is_bus_i |-> !trig_continuous_o;
  endproperty
  property p_abort_serial;
    s_take(OP_ABORT) ##0 !link_is_bus_i
      |-> ibuf_clear_o && obuf_clear_o && cycle_stop_o ##1 run_state_o != RUN_RUN;
  endproperty
  property p_abort_bus;
    s_take(OP_ABORT) ##0 link_is_bus_i |-> !ibuf_clear_o && !obuf_clear_o ##[1:2] std_event_o[5];
  endproperty
  property p_delay_hold;
    s_take(OP_SET_DELAY) |-> cycle_stop_o ##1 run_state_o == RUN_HOLD;
  endproperty
  property p_resp_hold;
    resp_o.valid && !resp_ready_i && !obuf_clear_o |=> resp_o.valid && $stable(resp_o.value);
  endproperty

  a_query_answer: assert property (p_query_answer) else $error("unit query unanswered");
  a_init_start: assert property (p_init_start) else $error("begin_single_reading did not start");
  a_avail_cause: assert property (p_avail_cause) else $error("avail without reading");
  a_fetch_clear: assert property (p_fetch_clear) else $error("fetch left avail set");
  a_trg_serial: assert property (p_trg_serial) else $error("serial trigger accepted");
  a_bus_single: assert property (p_bus_single) else $error("continuous on bus");
  a_abort_serial: assert property (p_abort_serial) else $error("abort incomplete");
  a_abort_bus: assert property (p_abort_bus) else $error("bus abort accepted");
  a_delay_hold: assert property (p_delay_hold) else $error("delay write not hold");
  a_resp_hold: assert property (p_resp_hold) else $error("response dropped");
endmodule
bind trig_cmd_engine trig_cmd_engine_checker u_checker (.ref_clk_i, .sys_rst_i,
  .link_is_bus_i, .cmd_i, .cmd_ready_o, .meas_i, .meas_start_o, .cycle_stop_o,
  .ibuf_clear_o, .obuf_clear_o, .resp_o, .resp_ready_i, .oper_cond_o, .std_event_o,
  .run_state_o, .trig_continuous_o);
`default_nettype wire

/* testbench/meas_engine_model.sv */
`timescale 1ns/100ps
`default_nettype none
module meas_engine_model
  import trig_cmd_pkg::*;
#(
  parameter logic [31:0] TEMP_VAL = 32'h0000_1234,
  parameter logic [31:0] RES_VAL = 32'h0000_5678,
  parameter logic [31:0] VOLT_VAL = 32'h0000_0ABC
)
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic rtd_i,
  input wire logic [4:0] lat_i,
  output trig_cmd_pkg::meas_t meas_o
);
  logic busy_q;
  logic [4:0] wait_q;
  logic done;

  assign done = busy_q && wait_q == 5'h00;

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || done)
      busy_q <= 1'b0;
    else if (start_i)
    begin
      busy_q <= 1'b1;
      wait_q <= lat_i;
    end
    else if (busy_q)
      wait_q <= wait_q - 5'h01;
  end

  // Values outside the done cycle are inverted so a late sample never matches
  always_comb
  begin
    meas_o = done ? '0 : '1;
    meas_o.done = done;
    meas_o.is_rtd = rtd_i;
    meas_o.temp = done ? TEMP_VAL : ~TEMP_VAL;
    meas_o.resist = done ? RES_VAL : ~RES_VAL;
    meas_o.volt = done ? VOLT_VAL : ~VOLT_VAL;
  end
endmodule
`default_nettype wire

/* testbench/test_measurement_trigger_command_engine.sv */
`timescale 1ns/100ps
`default_nettype none
`include "trig_cmd_defs.svh"
module test_measurement_trigger_command_engine;
  import trig_cmd_pkg::*;
  localparam logic [31:0] TEMP_VAL = 32'h0000_1234;
  localparam logic [31:0] VOLT_VAL = 32'h0000_0ABC;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i, link_is_bus_i, char_valid_i, char_term_i, char_ready_o, cmd_ready_o;
  logic stats_enabled_i, scan_enabled_i, resp_ready_i, meas_start_o, cycle_stop_o;
  logic ibuf_clear_o, obuf_clear_o, trig_continuous_o, probe_rtd, exec_seen, cmd_seen;
  logic [1:0] active_list_i;
  logic [3:0] list_channels_i [`NUM_LISTS];
  logic [4:0] lat;
  logic [15:0] oper_cond_o;
  logic [7:0] std_event_o;
  cmd_t cmd_i;
  meas_t meas_i;
  resp_t resp_o, got;
  run_state_t run_state_o;
  int failures, check_count;

  always #25 ref_clk_i = ~ref_clk_i;

  trig_cmd_engine dut (.ref_clk_i, .sys_rst_i, .link_is_bus_i, .char_valid_i, .char_term_i,
    .char_ready_o, .cmd_i, .cmd_ready_o, .meas_i, .stats_enabled_i, .active_list_i,
    .scan_enabled_i, .list_channels_i, .meas_start_o, .cycle_stop_o, .ibuf_clear_o,
    .obuf_clear_o, .resp_o, .resp_ready_i, .oper_cond_o, .std_event_o, .run_state_o,
    .trig_continuous_o);

  meas_engine_model #(.TEMP_VAL(TEMP_VAL), .VOLT_VAL(VOLT_VAL)) u_meas (.ref_clk_i,
    .sys_rst_i, .start_i(meas_start_o), .rtd_i(probe_rtd), .lat_i(lat), .meas_o(meas_i));

  always @(posedge ref_clk_i)
  begin
    if (std_event_o[4] === 1'b1) exec_seen <= 1'b1;
    if (std_event_o[5] === 1'b1) cmd_seen <= 1'b1;
  end

  // ****************
  // Shared tasks
  // ****************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task reset_dut(input logic bus);
    @(posedge ref_clk_i);
    link_is_bus_i <= bus;
    sys_rst_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  // One terminated message, then the parsed command once the engine is ready
  task send(input opcode_t o, input logic [2:0] a);
    cmd_t c;
    int n;
    c = '0;
    c.valid = 1'b1;
    c.op = o;
    c.unit = temp_unit_t'(a[1:0]);
    c.res = a[1:0];
    c.fn = fetch_fn_t'(a);
    c.continuous = a[0];
    c.cfg_rtd = probe_rtd;
    c.delay_sec = `DELAY_MAX_SEC;
    exec_seen = 1'b0;
    cmd_seen = 1'b0;
    @(posedge ref_clk_i);
    char_valid_i <= 1'b1;
    char_term_i <= 1'b1;
    @(posedge ref_clk_i);
    char_valid_i <= 1'b0;
    char_term_i <= 1'b0;
    for (n = 0; n < 60 && cmd_ready_o !== 1'b1; n++) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    cmd_i <= c;
    do
      @(posedge ref_clk_i);
    while (cmd_ready_o !== 1'b1);
    cmd_i.valid <= 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask

  task get_resp;
    int n;
    for (n = 0; n < 60 && resp_o.valid !== 1'b1; n++) @(negedge ref_clk_i);
    chk(resp_o.valid, 1'b1);
    got = resp_o;
    @(posedge ref_clk_i);
    resp_ready_i <= 1'b1;
    @(posedge ref_clk_i);
    resp_ready_i <= 1'b0;
  endtask

  task wait_avail;
    int n;
    for (n = 0; n < 60 && oper_cond_o[8] !== 1'b1; n++) @(negedge ref_clk_i);
  endtask

  // ****************
  // Scenarios
  // ****************
  // Unterminated characters fill the buffer; it empties once they stop
  task t_fill;
    @(posedge ref_clk_i);
    char_valid_i <= 1'b1;
    repeat (99) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(char_ready_o, 1'b1);
    @(posedge ref_clk_i);
    char_valid_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(char_ready_o, 1'b0);
    @(negedge ref_clk_i);
    chk(char_ready_o, 1'b1);
  endtask

  task t_unit_res;
    for (int i = 0; i < 4; i++)
    begin
      send(OP_SET_RES, 3'(i));
      send(OP_GET_RES, 3'h0);
      get_resp();
      chk(got.value[1:0], 32'(i));
    end
    for (int i = 2; i >= 0; i--)
    begin
      send(OP_SET_UNIT, 3'(i));
      send(OP_GET_UNIT, 3'h0);
      get_resp();
      chk(got.value[1:0], 32'(i));
      chk(got.unit, 32'(i));
    end
  endtask

  task t_init_fetch;
    send(OP_BEGIN_SINGLE_READING, 3'h0);
    wait_avail();
    chk(oper_cond_o[8], 1'b1);
    chk(run_state_o, RUN_SINGLE);
    send(OP_FETCH, 3'h0);
    get_resp();
    chk(got.value, TEMP_VAL);
    chk(oper_cond_o[8], 1'b0);
    send(OP_FETCH, 3'h3);
    get_resp();
    chk(got.value, VOLT_VAL);
    probe_rtd = 1'b1;
    lat = 5'h14;
    send(OP_CONFIGURE, 3'h0);
    send(OP_BEGIN_SINGLE_READING, 3'h0);
    wait_avail();
    send(OP_FETCH, 3'h3);
    get_resp();
    chk(got.error_value, 1'b1);
    chk(exec_seen, 1'b1);
    send(OP_FETCH, 3'h0);
    get_resp();
    chk(got.error_value, 1'b1);
    send(OP_READ, 3'h0);
    get_resp();
    chk(got.value, TEMP_VAL);
    send(OP_FETCH, 3'h0);
    get_resp();
    chk(got.error_value, 1'b0);
  endtask

  task t_serial_gate;
    send(OP_COMMON_TRIGGER, 3'h0);
    chk(cmd_seen, 1'b1);
    wait_avail();
    chk(oper_cond_o[8], 1'b0);
    send(OP_ABORT, 3'h0);
    chk(run_state_o, RUN_SINGLE);
    send(OP_GET_COUNT, 3'h0);
    get_resp();
    chk(got.continuous_count_token_token, 1'b1);
    send(OP_SET_TRIG_MODE, 3'h1);
    chk(trig_continuous_o, 1'b1);
    send(OP_SET_DELAY, 3'h0);
    chk(run_state_o, RUN_HOLD);
    send(OP_GET_DELAY, 3'h0);
    get_resp();
    chk(got.value, `DELAY_MAX_SEC);
    send(OP_SET_TRIG_MODE, 3'h0);
    chk(trig_continuous_o, 1'b0);
    send(OP_SET_TRIG_MODE, 3'h1);
    send(OP_READ, 3'h0);
    get_resp();
    chk(got.value, TEMP_VAL);
    chk(run_state_o, RUN_RUN);
    send(OP_ABORT, 3'h0);
    chk(run_state_o, RUN_HOLD);
    chk(trig_continuous_o, 1'b0);
  endtask

  task t_bus_gate;
    reset_dut(1'b1);
    send(OP_SET_TRIG_MODE, 3'h1);
    chk(cmd_seen, 1'b1);
    chk(trig_continuous_o, 1'b0);
    send(OP_ABORT, 3'h0);
    chk(cmd_seen, 1'b1);
    send(OP_COMMON_TRIGGER, 3'h0);
    wait_avail();
    chk(oper_cond_o[8], 1'b1);
    send(OP_MEASURE, 3'h0);
    get_resp();
    chk(got.value, TEMP_VAL);
    chk(run_state_o, RUN_SINGLE);
  endtask

  task complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    failures++;
    complete_run();
  end

  initial
  begin
    sys_rst_i = 1'b1;
    link_is_bus_i = 1'b0;
    char_valid_i = 1'b0;
    char_term_i = 1'b0;
    cmd_i = '0;
    stats_enabled_i = 1'b0;
    scan_enabled_i = 1'b0;
    active_list_i = 2'h0;
    list_channels_i = '{default: 4'h2};
    resp_ready_i = 1'b0;
    probe_rtd = 1'b0;
    lat = 5'h01;
    reset_dut(1'b0);
    @(negedge ref_clk_i);
    chk(resp_o.valid, 1'b0);
    chk(oper_cond_o[8], 1'b0);
    chk(run_state_o, RUN_SINGLE);
    t_fill();
    t_unit_res();
    t_init_fetch();
    t_serial_gate();
    t_bus_gate();
    complete_run();
  end
endmodule
`default_nettype wire
